// File: logic/edge_divider.sv
// divides a train of one-cycle input ticks by a fixed ratio
// assumes tick_in is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
module edge_divider #(
   parameter int RATIO = 10
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic tick_in,
   output logic tick_out
);

   logic [sum_loop_pkg::CNT_W-1:0] cnt_q;
   logic [sum_loop_pkg::CNT_W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   // ************************************************
   // counter
   // ************************************************
   always_comb
   begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!enable)
      begin
         // held cleared so a stopped divider makes no activity at all
         cnt_d = '0;
      end
      else if (tick_in)
      begin
         if (cnt_q == sum_loop_pkg::CNT_W'(RATIO - 1))
         begin
            cnt_d = '0;
            tick_d = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_out = tick_q;

   a_div_stopped: assert property (@(posedge clk) disable iff (!arst_n)
      !enable |=> (cnt_q == '0) && !tick_out)
      else $error("divider active while disabled");

endmodule

// File: logic/sum_loop_detector.sv
// sum loop phase/frequency detector, out-of-lock detector and frequency detector
// assumes all loop inputs are square waves already synchronous to clk
`timescale 1ns/10ps

module sum_loop_detector (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sum_vco,
   input wire logic ref_vco,
   input wire logic frac_ref,
   input wire logic if_square,
   output sum_loop_pkg::pd_out_t pd_out,
   output logic freq_error,
   output sum_loop_pkg::lock_status_t lock_status
);

   // ************************************************
   // input edge detection
   // ************************************************
   logic [sum_loop_pkg::LANES-1:0] in_now;
   logic [sum_loop_pkg::LANES-1:0] prev_q;
   logic [sum_loop_pkg::LANES-1:0] rise;

   assign in_now[sum_loop_pkg::LANE_SUM] = sum_vco;
   assign in_now[sum_loop_pkg::LANE_REF] = ref_vco;
   assign in_now[sum_loop_pkg::LANE_FRAC] = frac_ref;
   assign in_now[sum_loop_pkg::LANE_IF] = if_square;

   genvar gi;
   generate
      for (gi = 0; gi < sum_loop_pkg::LANES; gi++)
      begin : g_edge
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               prev_q[gi] <= 1'b0;
            end
            else
            begin
               prev_q[gi] <= in_now[gi];
            end
         end
         assign rise[gi] = in_now[gi] & ~prev_q[gi];
      end
   endgenerate

   // ************************************************
   // dividers
   // ************************************************
   logic ool_q;
   logic sum_tick;
   logic ref_tick;
   logic pd_ref_tick;

   edge_divider #(.RATIO(sum_loop_pkg::VCO_DIV)) sum_decade_divider (
      .clk(clk),
      .arst_n(arst_n),
      .enable(ool_q),
      .tick_in(rise[sum_loop_pkg::LANE_SUM]),
      .tick_out(sum_tick)
   );

   edge_divider #(.RATIO(sum_loop_pkg::VCO_DIV)) ref_decade_divider (
      .clk(clk),
      .arst_n(arst_n),
      .enable(ool_q),
      .tick_in(rise[sum_loop_pkg::LANE_REF]),
      .tick_out(ref_tick)
   );

   edge_divider #(.RATIO(sum_loop_pkg::PD_REF_DIV)) pd_ref_divider (
      .clk(clk),
      .arst_n(arst_n),
      .enable(1'b1),
      .tick_in(rise[sum_loop_pkg::LANE_FRAC]),
      .tick_out(pd_ref_tick)
   );

   // ************************************************
   // phase detector
   // ************************************************
   logic reference_flipflop_q;
   logic reference_flipflop_d;
   logic if_flipflop_q;
   logic if_flipflop_d;
   logic detector_reset_gate;

   always_comb
   begin
      reference_flipflop_d = reference_flipflop_q | pd_ref_tick;
      if_flipflop_d = if_flipflop_q | rise[sum_loop_pkg::LANE_IF];
      // gate acts on the next state so both outputs are never seen high together
      detector_reset_gate = reference_flipflop_d & if_flipflop_d;
      if (detector_reset_gate)
      begin
         reference_flipflop_d = 1'b0;
         if_flipflop_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reference_flipflop_q <= 1'b0;
         if_flipflop_q <= 1'b0;
      end
      else
      begin
         reference_flipflop_q <= reference_flipflop_d;
         if_flipflop_q <= if_flipflop_d;
      end
   end

   // width of each pulse is the gap between the two edges
   assign pd_out.up = reference_flipflop_q;
   assign pd_out.down = if_flipflop_q;

   // ************************************************
   // out-of-lock detector
   // ************************************************
   logic [sum_loop_pkg::CNT_W-1:0] width_q;
   logic [sum_loop_pkg::CNT_W-1:0] width_d;
   logic [sum_loop_pkg::CNT_W-1:0] hold_q;
   logic [sum_loop_pkg::CNT_W-1:0] hold_d;
   logic wide_trig;
   logic ool_d;

   always_comb
   begin
      width_d = '0;
      if (reference_flipflop_q | if_flipflop_q)
      begin
         width_d = width_q + 1'b1;
         if (width_q == sum_loop_pkg::CNT_W'(sum_loop_pkg::WIDE_PULSE_CYC))
         begin
            width_d = width_q;
         end
      end
      wide_trig = (width_q == sum_loop_pkg::CNT_W'(sum_loop_pkg::WIDE_PULSE_CYC - 1));
      hold_d = hold_q;
      if (wide_trig)
      begin
         // retriggerable: stays lit while wide pulses keep coming
         hold_d = sum_loop_pkg::CNT_W'(sum_loop_pkg::OOL_HOLD_CYC);
      end
      else if (hold_q != '0)
      begin
         hold_d = hold_q - 1'b1;
      end
      ool_d = (hold_d != '0);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         width_q <= '0;
         hold_q <= '0;
         ool_q <= 1'b0;
      end
      else
      begin
         width_q <= width_d;
         hold_q <= hold_d;
         ool_q <= ool_d;
      end
   end

   always_comb
   begin
      lock_status.status = '0;
      lock_status.status[sum_loop_pkg::STATUS_OOL_BIT] = ool_q;
      lock_status.lamp = ool_q;
      lock_status.freq_det_enable = ool_q;
   end

   // ************************************************
   // frequency comparator and error one-shot
   // ************************************************
   logic [1:0] sum_cnt_q;
   logic [1:0] sum_cnt_d;
   logic frequency_comparator_q;
   logic frequency_comparator_d;
   logic [sum_loop_pkg::CNT_W-1:0] err_cnt_q;
   logic [sum_loop_pkg::CNT_W-1:0] err_cnt_d;
   logic err_q;
   logic err_trig;

   always_comb
   begin
      sum_cnt_d = sum_cnt_q;
      frequency_comparator_d = frequency_comparator_q;
      if (!ool_q)
      begin
         sum_cnt_d = '0;
         frequency_comparator_d = 1'b0;
      end
      else if (ref_tick)
      begin
         // a reference period with no sum tick means sum is now slower
         if (sum_cnt_q == 2'h0 && !sum_tick)
         begin
            frequency_comparator_d = 1'b0;
         end
         sum_cnt_d = {1'b0, sum_tick};
      end
      else if (sum_tick)
      begin
         if (sum_cnt_q != 2'h0)
         begin
            // two sum ticks inside one reference period: sum is faster
            frequency_comparator_d = 1'b1;
         end
         if (sum_cnt_q != 2'h3)
         begin
            sum_cnt_d = sum_cnt_q + 2'h1;
         end
      end
      err_trig = ool_q & frequency_comparator_q & sum_tick;
      err_cnt_d = err_cnt_q;
      if (!ool_q)
      begin
         err_cnt_d = '0;
      end
      else if (err_cnt_q != '0)
      begin
         // triggers landing mid-pulse are dropped
         err_cnt_d = err_cnt_q - 1'b1;
      end
      else if (err_trig)
      begin
         err_cnt_d = sum_loop_pkg::CNT_W'(sum_loop_pkg::ERR_PULSE_CYC);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sum_cnt_q <= '0;
         frequency_comparator_q <= 1'b0;
         err_cnt_q <= '0;
         err_q <= 1'b0;
      end
      else
      begin
         sum_cnt_q <= sum_cnt_d;
         frequency_comparator_q <= frequency_comparator_d;
         err_cnt_q <= err_cnt_d;
         err_q <= (err_cnt_d != '0);
      end
   end

   assign freq_error = err_q;

   // ************************************************
   // assertions
   // ************************************************
   logic [sum_loop_pkg::CNT_W-1:0] err_len_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         err_len_q <= '0;
      end
      else if (err_q)
      begin
         err_len_q <= err_len_q + 1'b1;
      end
      else
      begin
         err_len_q <= '0;
      end
   end

   // enable dropping inside the eight watched cycles cuts the pulse legally, so demand enough hold left
   sequence s_idle_trigger;
      ool_q && frequency_comparator_q && sum_tick && (err_cnt_q == '0) && (hold_q > 16'h0008);
   endsequence

   sequence s_pulse_runs;
      err_q [*8];
   endsequence

   a_never_both_dir: assert property (@(posedge clk) disable iff (!arst_n)
      !(pd_out.up && pd_out.down))
      else $error("both direction outputs high");

   a_both_clear: assert property (@(posedge clk) disable iff (!arst_n)
      (pd_out.up && rise[sum_loop_pkg::LANE_IF]) |=> !pd_out.up && !pd_out.down)
      else $error("flip-flops not cleared when both set");

   a_ref_sets_up: assert property (@(posedge clk) disable iff (!arst_n)
      (pd_ref_tick && !pd_out.down && !rise[sum_loop_pkg::LANE_IF]) |=> pd_out.up)
      else $error("reference edge did not set flip-flop");

   a_err_starts: assert property (@(posedge clk) disable iff (!arst_n)
      s_idle_trigger |=> s_pulse_runs)
      else $error("error pulse did not start");

   a_err_width: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(err_q) && $past(ool_q) |-> err_len_q == sum_loop_pkg::CNT_W'(sum_loop_pkg::ERR_PULSE_CYC))
      else $error("error pulse width wrong");

   a_no_err_locked: assert property (@(posedge clk) disable iff (!arst_n)
      !ool_q |=> !freq_error)
      else $error("error pulse while locked");

   a_over_sets: assert property (@(posedge clk) disable iff (!arst_n)
      (ool_q && sum_tick && !ref_tick && sum_cnt_q != 2'h0) |=> frequency_comparator_q)
      else $error("comparator missed fast sum loop");

   a_wide_to_ool: assert property (@(posedge clk) disable iff (!arst_n)
      wide_trig |=> ool_q && lock_status.lamp && lock_status.status[sum_loop_pkg::STATUS_OOL_BIT])
      else $error("wide pulse did not flag out of lock");

endmodule

// File: logic/sum_loop_pkg.sv
// constants and carrier types for the sum loop phase/frequency detector
// assumes a single 100 MHz clock; all loop signals arrive already synchronous
package sum_loop_pkg;

   // ************************************************
   // clock and timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int ERR_PULSE_NS = 3400;
   // least time, so round up
   localparam int ERR_PULSE_CYC = (ERR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // detector pulse of this less one clock (490 ns) or longer counts as a wide pulse
   localparam int WIDE_PULSE_NS = 500;
   localparam int WIDE_PULSE_CYC = (WIDE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // out-of-lock one-shot stretch, longest time, so round down
   localparam int OOL_HOLD_NS = 40000;
   localparam int OOL_HOLD_CYC = OOL_HOLD_NS / CLK_PERIOD_NS;

   // ************************************************
   // divide ratios and widths
   // ************************************************
   localparam int VCO_DIV = 10;
   localparam int PD_REF_DIV = 100;
   localparam int CNT_W = 16;
   localparam int STATUS_OOL_BIT = 4;
   localparam int STATUS_W = 8;

   // ************************************************
   // edge detector lanes
   // ************************************************
   localparam int LANE_SUM = 0;
   localparam int LANE_REF = 1;
   localparam int LANE_FRAC = 2;
   localparam int LANE_IF = 3;
   localparam int LANES = 4;

   typedef struct packed {
      logic up;
      logic down;
   } pd_out_t;

   typedef struct packed {
      logic lamp;
      logic freq_det_enable;
      logic [STATUS_W-1:0] status;
   } lock_status_t;

endpackage

// File: tb/loop_signal_model.sv
// far-side square wave sources: sum vco, reference vco, fractional reference, squared if
// assumes the bench sets each half period in clk cycles; zero parks that line low
`timescale 1ns/10ps
module loop_signal_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0][15:0] half,
   output logic [3:0] wave
);
   // ************************************************
   // square wave generators
   // ************************************************
   logic [3:0][15:0] cnt_q;

   // a parked source drops low instead of freezing, so no stale level hides an edge later
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= '0;
         wave <= '0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (half[i] == 16'h0000)
            begin
               cnt_q[i] <= 16'h0000;
               wave[i] <= 1'b0;
            end
            else if (cnt_q[i] >= half[i] - 16'h0001)
            begin
               cnt_q[i] <= 16'h0000;
               wave[i] <= ~wave[i];
            end
            else
               cnt_q[i] <= cnt_q[i] + 16'h0001;
         end
      end
   end
endmodule

// File: tb/tb.sv
// self-checking bench for the sum loop phase/frequency detector
// assumes loop_signal_model supplies the four loop signals as slow square waves
`timescale 1ns/10ps
module tb;
   logic clk;
   logic arst_n;
   logic [3:0][15:0] half;
   logic [3:0] wave;
   sum_loop_pkg::pd_out_t pd_out;
   logic freq_error;
   sum_loop_pkg::lock_status_t lock_status;
   int miscompares;
   int checks_done;
   int frac_rises = 0;
   int err_run = 0;
   logic frac_q = 1'b0;
   logic hi;

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   loop_signal_model u_far (.clk(clk), .arst_n(arst_n), .half(half), .wave(wave));
   sum_loop_detector u_dut (.clk(clk), .arst_n(arst_n), .sum_vco(wave[sum_loop_pkg::LANE_SUM]),
      .ref_vco(wave[sum_loop_pkg::LANE_REF]), .frac_ref(wave[sum_loop_pkg::LANE_FRAC]),
      .if_square(wave[sum_loop_pkg::LANE_IF]), .pd_out(pd_out), .freq_error(freq_error),
      .lock_status(lock_status));

   // ************************************************
   // compare, wait and closing tasks
   // ************************************************
   task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
      checks_done++;
      if (act !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s is %h, expected %h", $time, what, act, exp);
      end
   endtask

   function automatic logic probe(input int sel);
      case (sel)
         0: return freq_error;
         1: return pd_out.up;
         2: return lock_status.freq_det_enable;
         3: return pd_out === 2'b00;
         default: return wave[sum_loop_pkg::LANE_IF];
      endcase
   endfunction

   // bounded wait; running out of cycles shows up as a miscompare
   task automatic wait_for(input int sel, input logic lvl, input int limit, input string what);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (probe(sel) !== lvl && n < limit);
      check({15'h0000, probe(sel)}, {15'h0000, lvl}, what);
   endtask

   task automatic results();
      $display("checks %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ************************************************
   // monitors
   // ************************************************
   always @(posedge clk)
   begin
      if (arst_n)
      begin
         check({15'h0000, pd_out.up & pd_out.down}, 16'h0000, "up and down together");
         if (wave[sum_loop_pkg::LANE_FRAC] && !frac_q)
            frac_rises <= frac_rises + 1;
         frac_q <= wave[sum_loop_pkg::LANE_FRAC];
         if (freq_error)
            err_run <= err_run + 1;
         else
         begin
            // a pulse cut short by the enable dropping is legal, so skip it
            if (err_run != 0 && lock_status.freq_det_enable)
               check(16'(err_run), 16'h0154, "error pulse width");
            err_run <= 0;
         end
      end
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial
   begin
      arst_n = 1'b0;
      half = '0;
      miscompares = 0;
      checks_done = 0;
      hi = 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      check({3'h0, pd_out, freq_error, lock_status}, 16'h0000, "outputs after reset");
      half[sum_loop_pkg::LANE_FRAC] <= 16'h0004;
      wait_for(1, 1'b1, 1000, "up after reference");
      check(16'(frac_rises), 16'h0064, "reference rises before up");
      check({6'h00, lock_status}, 16'h0000, "lock before wide pulse");
      repeat (60) @(posedge clk);
      check({6'h00, lock_status}, 16'h0310, "out of lock status");
      check({14'h0000, pd_out}, 16'h0002, "up held until if edge");
      half[sum_loop_pkg::LANE_IF] <= 16'h00c8;
      wait_for(4, 1'b1, 400, "if edge");
      repeat (2) @(posedge clk);
      check({14'h0000, pd_out}, 16'h0000, "both flip-flops cleared");
      half[sum_loop_pkg::LANE_SUM] <= 16'h0001;
      half[sum_loop_pkg::LANE_REF] <= 16'h0005;
      wait_for(0, 1'b1, 2000, "error pulse while sum fast");
      repeat (3)
      begin
         wait_for(0, 1'b0, 400, "error pulse end");
         wait_for(0, 1'b1, 40, "error pulse train");
      end
      half[sum_loop_pkg::LANE_SUM] <= 16'h000a;
      wait_for(0, 1'b0, 400, "last error pulse end");
      repeat (400) @(posedge clk);
      hi = 1'b0;
      repeat (1000)
      begin
         @(posedge clk);
         hi |= freq_error;
      end
      check({15'h0000, hi}, 16'h0000, "no error pulse while sum slow");
      half[sum_loop_pkg::LANE_SUM] <= 16'h0001;
      wait_for(3, 1'b1, 1000, "detector idle");
      half[sum_loop_pkg::LANE_FRAC] <= 16'h0000;
      half[sum_loop_pkg::LANE_IF] <= 16'h0000;
      wait_for(2, 1'b0, 4600, "lock regained");
      check({6'h00, lock_status}, 16'h0000, "locked status");
      repeat (2) @(posedge clk);
      hi = 1'b0;
      repeat (500)
      begin
         @(posedge clk);
         hi |= freq_error;
      end
      check({15'h0000, hi}, 16'h0000, "no error pulse while locked");
      results();
   end
endmodule
